// ### kpl_pkg.sv
package kpl_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] CFG_ADDR = 8'h01;
  localparam logic [7:0] STAT_ADDR = 8'h02;
  localparam logic [7:0] LEC_ADDR = 8'h03;
  localparam logic [7:0] EVT_ADDR = 8'h04;
  localparam logic [7:0] UNL1_ADDR = 8'h0F;
  localparam logic [7:0] UNL2_ADDR = 8'h10;
  localparam logic [7:0] LTMR_ADDR = 8'h11;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_KE_IEN = 0;
  localparam int CFG_IN_IEN = 1;
  localparam int CFG_KL_IEN = 2;
  localparam int CFG_OV_IEN = 3;
  localparam int CFG_RETRIG = 4;
  localparam int CFG_OV_MODE = 5;
  localparam int CFG_IN_EM = 6;
  localparam int ST_KEY = 0;
  localparam int ST_IN = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_OVF = 3;
  localparam int ST_COMBO = 4;
  localparam int LEC_LOCK_EN = 6;
  localparam int STAT_W = 5;

  // ----------------------------------------
  // event codes and fixed combo keys
  // ----------------------------------------
  localparam int EVT_PRESS_BIT = 7;
  localparam logic [6:0] COMBO_K1 = 7'h01;
  localparam logic [6:0] COMBO_K2 = 7'h0B;
  localparam logic [6:0] COMBO_K3 = 7'h15;
  localparam logic [6:0] GPI_FIRST = 7'h61;
  localparam logic [6:0] GPI_LAST = 7'h72;
  localparam logic [6:0] KEY_LAST = 7'h50;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int RETRIG_US = 50;
  localparam int RETRIG_CYC = RETRIG_US * CLK_MHZ;
  localparam int SEC_CYC = 250_000_000;

  typedef enum logic [1:0] {KPL_UNLOCKED, KPL_WAIT_FIRST, KPL_WAIT_SECOND} kpl_lock_e;
  typedef enum logic {KPL_IDLE_SCAN, KPL_ACTIVE_SCAN} kpl_scan_e;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } kpl_req_s;

  // key event from the scan front end
  typedef struct packed {
    logic valid;
    logic press;
    logic [6:0] code;
  } kpl_evt_s;

endpackage : kpl_pkg

// ### kpl_evt_fifo.sv
`timescale 1ns/100ps
module kpl_evt_fifo #(
  parameter int DEPTH = 10
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // push side
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic wrap_mode,
  // pop side
  input wire logic pop,
  output logic [7:0] head,
  output logic [3:0] count,
  output logic full
);
  import kpl_pkg::*;

  logic [7:0] mem_reg [DEPTH];
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic do_push;
  logic do_shift;

  // ----------------------------------------
  // control decode
  // ----------------------------------------
  assign full = (count_reg == 4'(DEPTH));
  assign do_push = push && (!full || wrap_mode);
  assign do_shift = (pop && count_reg != 4'h0) || (push && full && wrap_mode);
  assign head = mem_reg[0];
  assign count = count_reg;
  assign count_next = (count_reg + 4'(do_push)) - 4'(do_shift);

  // shift-down storage, newest at top of occupied slots
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 4'h0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= REG_RESET;
      end
    end else begin
      count_reg <= count_next;
      for (int i = 0; i < DEPTH; i++) begin
        if (do_push && int'(count_next) - 1 == i) begin
          mem_reg[i] <= push_data;
        end else if (do_shift) begin
          mem_reg[i] <= (i == DEPTH - 1) ? REG_RESET : mem_reg[(i + 1) % DEPTH];
        end
      end
    end
  end

endmodule : kpl_evt_fifo

// ### kpl_core.sv
`timescale 1ns/100ps
// Summary of operation
// - wrap mode: drop oldest, append new
// - default mode: drop new event when full
// - event bit7 press, low bits key code
// - lock blocks key events and key interrupts
// - unlock keys: any matrix or input code
// - locked with mask: first press interrupts
// - lock interrupt after both keys in order
// - mask timeout resets unlock sequence
// - lock timer bits 2:0 key gap seconds
// - lock timer bits 7:3 mask seconds
// - writing lock enable zero unlocks
// - keys 1, 11, 21 together flag combo
// - input pin edge raises interrupt
// - change clears on return or read
// - outputs never interrupt; switch may spuriously
// - interrupt pin open-drain active low
// - retrigger: clear while pending gives 50us release
// - no retrigger: pin stays low
// - reset sets every register to default
// - idle: columns low, rows pulled up inputs
// - oscillator stopped while idle
// - row low starts active scan; release idles
// - event into full FIFO sets overflow flag
// - configuration bit layout
// - status bits cleared by writing one
// - lock/count register layout
module kpl_core #(
  parameter int DEPTH = 10,
  parameter int ROWS = 8,
  parameter int COLS = 10,
  parameter int PINS = 18,
  parameter int RETRIG_CYCLES = kpl_pkg::RETRIG_CYC,
  parameter int SEC_CYCLES = kpl_pkg::SEC_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register access from serial bus engine
  input wire kpl_pkg::kpl_req_s req,
  input wire logic ack_phase,
  output logic [7:0] rdata,
  // scanned key events and matrix state
  input wire kpl_pkg::kpl_evt_s evt,
  input wire logic combo_held,
  input wire logic scan_done,
  // input pins
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_is_input,
  // keypad matrix pins
  input wire logic [ROWS-1:0] row_in,
  output logic [COLS-1:0] col_out,
  output logic [COLS-1:0] col_oe_n,
  output logic [ROWS-1:0] row_pullup_en,
  output logic osc_run,
  // interrupt pin
  output logic int_out,
  output logic int_oe_n
);
  import kpl_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] cfg_reg;
  logic [STAT_W-1:0] stat_reg;
  logic [STAT_W-1:0] stat_next;
  logic lock_en_reg;
  logic [6:0] unl1_reg;
  logic [6:0] unl2_reg;
  logic [7:0] ltmr_reg;
  logic [PINS-1:0] in_ref_reg;
  logic [PINS-1:0] chg_reg;
  logic combo_seen_reg;
  kpl_lock_e lock_reg;
  kpl_lock_e lock_next;
  kpl_scan_e scan_reg;
  // one-second base, gap and mask timers
  logic [31:0] tick_cnt_reg;
  logic [5:0] sec_cnt_reg;
  logic [2:0] gap_cnt_reg;
  logic first_seen_reg;
  logic [31:0] hold_cnt_reg;
  logic int_pend_d_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic wr_hit(input kpl_req_s r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction : wr_hit

  function automatic logic valid_code(input logic [6:0] c);
    return (c != 7'h00 && c <= KEY_LAST) || (c >= GPI_FIRST && c <= GPI_LAST);
  endfunction : valid_code

  wire is_gpi = evt.code >= GPI_FIRST;
  wire lock_on = lock_en_reg;
  wire mask_on = ltmr_reg[7:3] != 5'h00;
  wire evt_ok = evt.valid && valid_code(evt.code);
  // gpi events are still recorded while locked unless input event mode is set
  wire evt_blocked = lock_on && (!is_gpi || cfg_reg[CFG_IN_EM]);
  wire fifo_push = evt_ok && !evt_blocked;
  wire [7:0] evt_byte = {evt.press, evt.code};
  wire fifo_full;
  wire [7:0] fifo_head;
  wire [3:0] fifo_count;
  // read side effects happen only in the acknowledge phase
  wire evt_rd = req.rd && req.addr == EVT_ADDR && ack_phase;
  wire ovf_set = fifo_push && fifo_full;
  wire press_any = evt_ok && evt.press;
  wire sec_tick = tick_cnt_reg == 32'(SEC_CYCLES - 1);
  wire unl_first = press_any && evt.code == unl1_reg;
  wire unl_second = press_any && evt.code == unl2_reg;
  wire unlock_done = (lock_reg == KPL_WAIT_SECOND) && unl_second;
  wire mask_expired = sec_tick && mask_on && (sec_cnt_reg == 6'({1'b0, ltmr_reg[7:3]}));
  wire gap_expired = sec_tick && (gap_cnt_reg == ltmr_reg[2:0]);
  // input-pin change: any edge of an input pin, outputs excluded
  wire [PINS-1:0] chg_now = (pin_in ^ in_ref_reg) & pin_is_input;
  wire in_rd = req.rd && ack_phase && req.addr == STAT_ADDR;
  wire combo_rise = combo_held && !combo_seen_reg;
  wire key_irq_evt = fifo_push || (lock_on && mask_on && press_any && !first_seen_reg);

  // ----------------------------------------
  // event fifo
  // ----------------------------------------
  kpl_evt_fifo #(.DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .push(fifo_push),
    .push_data(evt_byte),
    .wrap_mode(cfg_reg[CFG_OV_MODE]),
    .pop(evt_rd),
    .head(fifo_head),
    .count(fifo_count),
    .full(fifo_full)
  );

  // ----------------------------------------
  // status set and write-one clear, set wins
  // ----------------------------------------
  wire [STAT_W-1:0] stat_set = {combo_rise, ovf_set, unlock_done, |chg_now, key_irq_evt};
  wire [STAT_W-1:0] stat_clr = wr_hit(req, STAT_ADDR) ? req.wdata[STAT_W-1:0] : '0;
  // input flag follows the pin: dropped once it returns to its reference
  wire [STAT_W-1:0] in_drop = STAT_W'(!(|chg_now)) << ST_IN;
  assign stat_next = (stat_reg & ~stat_clr & ~in_drop) | stat_set;

  // ----------------------------------------
  // unlock sequence
  // ----------------------------------------
  // waits for first then second key, falls back on timeout
  always_comb begin
    lock_next = lock_reg;
    unique case (lock_reg)
      KPL_UNLOCKED: begin
        if (lock_on) begin
          lock_next = KPL_WAIT_FIRST;
        end
      end
      KPL_WAIT_FIRST: begin
        if (unl_first) begin
          lock_next = KPL_WAIT_SECOND;
        end
      end
      KPL_WAIT_SECOND: begin
        if (unl_second) begin
          lock_next = KPL_UNLOCKED;
        end else if (gap_expired || mask_expired) begin
          lock_next = KPL_WAIT_FIRST;
        end
      end
    endcase
    if (!lock_on) begin
      lock_next = KPL_UNLOCKED;
    end
  end

  // ----------------------------------------
  // config and lock registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= REG_RESET;
      unl1_reg <= 7'h00;
      unl2_reg <= 7'h00;
      ltmr_reg <= REG_RESET;
      stat_reg <= '0;
      lock_reg <= KPL_UNLOCKED;
    end else begin
      if (wr_hit(req, CFG_ADDR)) begin
        cfg_reg <= req.wdata;
      end
      if (wr_hit(req, UNL1_ADDR)) begin
        unl1_reg <= req.wdata[6:0];
      end
      if (wr_hit(req, UNL2_ADDR)) begin
        unl2_reg <= req.wdata[6:0];
      end
      if (wr_hit(req, LTMR_ADDR)) begin
        ltmr_reg <= req.wdata;
      end
      stat_reg <= stat_next;
      lock_reg <= lock_next;
    end
  end

  // lock enable: host write, cleared by a good unlock sequence
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_en_reg <= 1'b0;
    end else if (wr_hit(req, LEC_ADDR)) begin
      lock_en_reg <= req.wdata[LEC_LOCK_EN];
    end else if (unlock_done) begin
      lock_en_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // second timer, gap and mask counters
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 32'h0000_0000;
      sec_cnt_reg <= 6'h00;
      gap_cnt_reg <= 3'h0;
      first_seen_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= (sec_tick || lock_reg == KPL_UNLOCKED) ? 32'h0000_0000 : tick_cnt_reg + 1;
      // gap timer only runs while waiting for the second key
      if (lock_next != KPL_WAIT_SECOND || unl_first) begin
        gap_cnt_reg <= 3'h0;
      end else if (sec_tick) begin
        gap_cnt_reg <= gap_cnt_reg + 3'h1;
      end
      if (lock_reg == KPL_UNLOCKED || mask_expired) begin
        sec_cnt_reg <= 6'h00;
        first_seen_reg <= 1'b0;
      end else begin
        if (sec_tick) begin
          sec_cnt_reg <= sec_cnt_reg + 6'h01;
        end
        if (press_any) begin
          first_seen_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // input change tracking
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_ref_reg <= '0;
      chg_reg <= '0;
      combo_seen_reg <= 1'b0;
    end else begin
      chg_reg <= chg_now;
      // reference follows the pin when read at ack; return to level clears itself
      if (in_rd) begin
        in_ref_reg <= pin_in;
      end
      combo_seen_reg <= combo_held;
    end
  end

  // ----------------------------------------
  // interrupt pin with optional release pulse
  // ----------------------------------------
  // combo has no enable bit, so it is always allowed
  wire [STAT_W-1:0] ien = {1'b1, cfg_reg[CFG_OV_IEN], cfg_reg[CFG_KL_IEN],
                           cfg_reg[CFG_IN_IEN], cfg_reg[CFG_KE_IEN]};
  // status as the host sees it, live input change folded in
  wire [STAT_W-1:0] stat_view = {stat_reg[ST_COMBO:ST_LOCK], stat_reg[ST_IN] | (|chg_reg),
                                 stat_reg[ST_KEY]};
  // while unlocked, unread events keep the key interrupt pending after a clear
  wire [STAT_W-1:0] live = {stat_view[ST_COMBO:ST_IN],
                            stat_view[ST_KEY] | (fifo_count != 4'h0 && !lock_on)};
  wire int_pend = |(live & ien);
  wire clr_try = wr_hit(req, STAT_ADDR) && (req.wdata[STAT_W-1:0] != '0);

  // release timer reloads on a clear attempt while asserted
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_cnt_reg <= 32'h0000_0000;
      int_pend_d_reg <= 1'b0;
    end else begin
      int_pend_d_reg <= int_pend;
      if (clr_try && int_pend_d_reg && cfg_reg[CFG_RETRIG]) begin
        hold_cnt_reg <= 32'(RETRIG_CYCLES);
      end else if (hold_cnt_reg != 32'h0000_0000) begin
        hold_cnt_reg <= hold_cnt_reg - 1;
      end
    end
  end

  // pin only ever pulls low, released during the retrigger gap
  assign int_out = 1'b0;
  assign int_oe_n = !(int_pend_d_reg && hold_cnt_reg == 32'h0000_0000);

  // ----------------------------------------
  // scan mode and oscillator gating
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scan_reg <= KPL_IDLE_SCAN;
    end else if (scan_reg == KPL_IDLE_SCAN && row_in != '1) begin
      scan_reg <= KPL_ACTIVE_SCAN;
    end else if (scan_reg == KPL_ACTIVE_SCAN && scan_done) begin
      scan_reg <= KPL_IDLE_SCAN;
    end
  end

  // fixed idle matrix setup, oscillator follows scan state
  assign osc_run = scan_reg == KPL_ACTIVE_SCAN;
  assign col_out = '0;
  assign col_oe_n = '0;
  assign row_pullup_en = '1;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // registered read data for the addressed register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= REG_RESET;
    end else begin
      unique case (req.addr)
        CFG_ADDR: rdata <= cfg_reg;
        STAT_ADDR: rdata <= 8'(stat_view);
        LEC_ADDR: rdata <= {1'b0, lock_en_reg, lock_reg == KPL_WAIT_SECOND,
                            lock_reg == KPL_WAIT_FIRST, fifo_count};
        EVT_ADDR: rdata <= fifo_head;
        UNL1_ADDR: rdata <= {1'b0, unl1_reg};
        UNL2_ADDR: rdata <= {1'b0, unl2_reg};
        LTMR_ADDR: rdata <= ltmr_reg;
        default: rdata <= REG_RESET;
      endcase
    end
  end

endmodule : kpl_core

// ### kpl_host_model.sv
`timescale 1ns/100ps
module kpl_host_model (
  // clock
  input wire logic ref_clk,
  // register access toward the core
  output kpl_pkg::kpl_req_s req,
  output logic ack_phase,
  input wire logic [7:0] rdata
);
  import kpl_pkg::*;

  // bus idle from time zero
  initial begin
    req = '0;
    ack_phase = 1'b0;
  end

  // one-cycle write strobe, host sets timers, lock and w1c flags
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    req = '0;
  endtask : wr_reg

  // read strobe held through the acknowledge phase, where pops and re-reference land
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    ack_phase = 1'b1;
    d = rdata;
    @(negedge ref_clk);
    req = '0;
    ack_phase = 1'b0;
  endtask : rd_reg
endmodule : kpl_host_model

// ### kpl_core_checker.sv
`timescale 1ns/100ps
module kpl_core_checker #(
  parameter int ROWS = 8,
  parameter int COLS = 10
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register access and events
  input wire kpl_pkg::kpl_req_s req,
  input wire logic [7:0] rdata,
  input wire logic combo_held,
  input wire logic scan_done,
  // matrix and interrupt pins
  input wire logic [ROWS-1:0] row_in,
  input wire logic [COLS-1:0] col_out,
  input wire logic [COLS-1:0] col_oe_n,
  input wire logic [ROWS-1:0] row_pullup_en,
  input wire logic osc_run,
  input wire logic int_out,
  input wire logic int_oe_n
);
  import kpl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // all rows released
  wire logic rows_up = (row_in == '1);

  a_int_never_high: assert property (int_out == 1'b0)
    else $error("interrupt pin driven high");
  a_cols_idle_low: assert property (col_out == '0 && col_oe_n == '0 && row_pullup_en == '1)
    else $error("matrix pins not in idle setup");
  a_reset_defaults: assert property ($fell(rst) |-> int_oe_n && !osc_run)
    else $error("outputs not at default after reset");
  a_row_wakes_osc: assert property (!rows_up |-> ##[1:4] osc_run)
    else $error("row low did not start oscillator");
  a_idle_osc_off: assert property (!osc_run && rows_up |=> !osc_run)
    else $error("oscillator started while idle");
  a_release_idles: assert property (osc_run && rows_up && scan_done |-> ##[1:2] !osc_run)
    else $error("no return to idle after release");
  a_combo_irq: assert property ($rose(combo_held) |-> ##[1:3] !int_oe_n)
    else $error("combo did not assert interrupt");
  a_timer_reg_rw: assert property ((req.wr && req.addr == LTMR_ADDR) ##2
    (req.rd && req.addr == LTMR_ADDR) |=> rdata == $past(req.wdata, 3))
    else $error("timer register readback wrong");
endmodule : kpl_core_checker

bind kpl_core kpl_core_checker #(.ROWS(ROWS), .COLS(COLS)) u_kpl_core_checker (
  .ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .combo_held(combo_held),
  .scan_done(scan_done), .row_in(row_in), .col_out(col_out), .col_oe_n(col_oe_n),
  .row_pullup_en(row_pullup_en), .osc_run(osc_run), .int_out(int_out), .int_oe_n(int_oe_n)
);

// ### kpl_core_bench.sv
`timescale 1ns/100ps
module kpl_core_bench;
  import kpl_pkg::*;
  localparam int RC = 20;
  logic ref_clk, rst, ack_phase, combo_held, scan_done, osc_run, int_out, int_oe_n;
  logic [7:0] rdata;
  kpl_req_s req;
  kpl_evt_s evt;
  logic [17:0] pin_in, pin_is_input;
  logic [7:0] row_in, row_pullup_en;
  logic [9:0] col_out, col_oe_n;
  logic [7:0] regs [6] = '{CFG_ADDR, STAT_ADDR, LEC_ADDR, UNL1_ADDR, UNL2_ADDR, LTMR_ADDR};
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  kpl_core #(.RETRIG_CYCLES(RC), .SEC_CYCLES(100)) u_kpl_core (
    .ref_clk(ref_clk), .rst(rst), .req(req), .ack_phase(ack_phase), .rdata(rdata),
    .evt(evt), .combo_held(combo_held), .scan_done(scan_done), .pin_in(pin_in),
    .pin_is_input(pin_is_input), .row_in(row_in), .col_out(col_out), .col_oe_n(col_oe_n),
    .row_pullup_en(row_pullup_en), .osc_run(osc_run), .int_out(int_out), .int_oe_n(int_oe_n)
  );
  kpl_host_model u_kpl_host_model (.ref_clk(ref_clk), .req(req), .ack_phase(ack_phase),
    .rdata(rdata));

  // clock and hang guard
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    u_kpl_host_model.rd_reg(a, d);
    chk(d & m, exp);
  endtask : rchk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_kpl_host_model.wr_reg(a, d);
  endtask : wr

  task automatic key(input logic p, input logic [6:0] c);
    @(negedge ref_clk);
    evt = '{valid: 1'b1, press: p, code: c};
    @(negedge ref_clk);
    evt = '0;
  endtask : key

  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    int n;
    ref_clk = 1'b0;
    rst = 1'b1;
    evt = '0;
    combo_held = 1'b0;
    scan_done = 1'b0;
    pin_in = '0;
    pin_is_input = '0;
    row_in = '1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    foreach (regs[i]) rchk(regs[i], 8'hFF, 8'h00);
    chk({7'h0, int_oe_n}, 8'h01);
    $display("test reset done");
    // overflow drops the new event, pin held while pending
    wr(CFG_ADDR, 8'h09);
    for (int i = 1; i <= 11; i++) key(1'b1, 7'(i));
    rchk(LEC_ADDR, 8'h0F, 8'h0A);
    rchk(STAT_ADDR, 8'h1F, 8'h09);
    wr(STAT_ADDR, 8'h01);
    for (int i = 0; i < 4; i++) @(negedge ref_clk) chk({7'h0, int_oe_n}, 8'h00);
    for (int i = 1; i <= 10; i++) rchk(EVT_ADDR, 8'hFF, {1'b1, 7'(i)});
    rchk(LEC_ADDR, 8'h0F, 8'h00);
    wr(STAT_ADDR, 8'h1F);
    rchk(STAT_ADDR, 8'hFF, 8'h00);
    $display("test overflow drop done");
    // wrap mode keeps the newest ten
    wr(CFG_ADDR, 8'h29);
    for (int i = 1; i <= 11; i++) key(1'b0, 7'(i));
    for (int i = 2; i <= 11; i++) rchk(EVT_ADDR, 8'hFF, {1'b0, 7'(i)});
    wr(STAT_ADDR, 8'h1F);
    $display("test overflow wrap done");
    // retrigger release while an event is pending
    wr(CFG_ADDR, 8'h19);
    key(1'b1, 7'h21);
    key(1'b1, 7'h22);
    wr(STAT_ADDR, 8'h01);
    n = 0;
    for (int i = 0; i < 10 && int_oe_n !== 1'b1; i++) @(negedge ref_clk);
    while (int_oe_n === 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk(8'((n >= RC - 1) && (n <= RC + 1)), 8'h01);
    rchk(EVT_ADDR, 8'hFF, 8'hA1);
    rchk(EVT_ADDR, 8'hFF, 8'hA2);
    wr(STAT_ADDR, 8'h1F);
    $display("test retrigger done");
    // lock blocks events, manual unlock restores them
    wr(CFG_ADDR, 8'h01);
    wr(LEC_ADDR, 8'h40);
    rchk(LEC_ADDR, 8'h40, 8'h40);
    key(1'b1, 7'h33);
    rchk(LEC_ADDR, 8'h0F, 8'h00);
    rchk(STAT_ADDR, 8'h1F, 8'h00);
    wr(LEC_ADDR, 8'h00);
    key(1'b1, 7'h33);
    rchk(LEC_ADDR, 8'h0F, 8'h01);
    rchk(EVT_ADDR, 8'hFF, 8'hB3);
    wr(STAT_ADDR, 8'h1F);
    $display("test lock done");
    // unlock sequence and mask timeout
    wr(UNL1_ADDR, {1'b0, GPI_FIRST});
    wr(UNL2_ADDR, 8'h05);
    wr(LTMR_ADDR, 8'h09);
    rchk(LTMR_ADDR, 8'hFF, 8'h09);
    wr(CFG_ADDR, 8'h05);
    wr(LEC_ADDR, 8'h40);
    key(1'b1, 7'h07);
    rchk(STAT_ADDR, 8'h01, 8'h01);
    key(1'b1, GPI_FIRST);
    key(1'b1, 7'h05);
    rchk(STAT_ADDR, 8'h04, 8'h04);
    wr(STAT_ADDR, 8'h1F);
    wr(LEC_ADDR, 8'h40);
    key(1'b1, GPI_FIRST);
    repeat (400) @(negedge ref_clk);
    key(1'b1, 7'h05);
    rchk(STAT_ADDR, 8'h04, 8'h00);
    wr(LEC_ADDR, 8'h00);
    wr(STAT_ADDR, 8'h1F);
    $display("test unlock done");
    // input pins: outputs quiet, inputs raise the flag
    wr(CFG_ADDR, 8'h02);
    pin_is_input = 18'h0_0001;
    repeat (2) @(negedge ref_clk);
    pin_in[1] = 1'b1;
    rchk(STAT_ADDR, 8'h02, 8'h00);
    pin_in[0] = 1'b1;
    rchk(STAT_ADDR, 8'h02, 8'h02);
    pin_in[0] = 1'b0;
    repeat (2) @(negedge ref_clk);
    pin_in[0] = 1'b1;
    rchk(STAT_ADDR, 8'h02, 8'h00);
    wr(STAT_ADDR, 8'h1F);
    combo_held = 1'b1;
    repeat (4) @(negedge ref_clk);
    rchk(STAT_ADDR, 8'h10, 8'h10);
    combo_held = 1'b0;
    $display("test pins and combo done");
    // wake on a row, back to idle on release
    row_in[2] = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk({7'h0, osc_run}, 8'h01);
    row_in = '1;
    scan_done = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({7'h0, osc_run}, 8'h00);
    scan_done = 1'b0;
    $display("test scan modes done");
    final_report();
  end
endmodule : kpl_core_bench
